/* rtl/sdc_regs.sv */
`timescale 1ns/1ns
module sdc_regs
    import sdc_pkg::*;
#(
    // Output disable reset value differs between device variants
    parameter logic HIZ_RESET = 1'b0
)
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe_n,
    input wire logic step_pin,
    input wire logic dir_pin,
    input wire logic drive_off_pin,
    output logic [3:0] torque_scale,
    output logic [1:0] slew_select,
    output logic [1:0] pwm_off_time,
    output logic [2:0] decay_mode,
    output logic [3:0] substep_resolution,
    output logic step_dir,
    output logic step_pulse,
    output logic outputs_hiz,
    output logic fault_clear_pulse
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic sclk_m;
        logic sclk_s;
        logic sclk_p;
        logic cs_m;
        logic cs_s;
        logic cs_p;
        logic mosi_m;
        logic mosi_s;
        logic step_m;
        logic step_s;
        logic step_p;
        logic dir_m;
        logic dir_s;
        logic off_m;
        logic off_s;
        logic [4:0] bit_cnt;
        logic [15:0] shift_in;
        logic [7:0] shift_out;
        logic miso;
        logic miso_oe_n;
        logic [7:0] torque_slew;
        logic [7:0] output_chop;
        logic [7:0] step_motion;
        logic [2:0] lock;
        logic step_pulse;
        logic step_dir;
        logic hiz;
        logic flt_clr;
    } sdc_state_s;

    localparam sdc_state_s RST_STATE = '{
        cs_m: 1'b1,
        cs_s: 1'b1,
        cs_p: 1'b1,
        miso_oe_n: 1'b1,
        torque_slew: TORQUE_SLEW_RESET,
        output_chop: {HIZ_RESET, OUTPUT_CHOP_RESET},
        step_motion: STEP_MOTION_RESET,
        lock: LOCK_OFF,
        hiz: HIZ_RESET,
        default: '0
    };

    sdc_state_s q;
    sdc_state_s d;

    function automatic logic hit(input logic [5:0] addr, input logic [5:0] target);
        hit = (addr == target);
    endfunction : hit

    function automatic logic [7:0] read_mux(input logic [5:0] addr, input sdc_state_s s);
        read_mux = 8'h00;
        if (hit(addr, ADDR_TORQUE_SLEW))
            read_mux = s.torque_slew;
        else if (hit(addr, ADDR_OUTPUT_CHOP))
            read_mux = s.output_chop;
        else if (hit(addr, ADDR_STEP_MOTION))
            read_mux = s.step_motion;
        else if (hit(addr, ADDR_LOCK_CTRL))
            read_mux = {1'b0, s.lock, 4'h0};
    endfunction : read_mux

    // ------------------------------------------------------------
    // Frame decode
    // ------------------------------------------------------------
    logic sclk_rise;
    logic sclk_fall;
    logic in_frame;
    logic commit;
    logic locked;
    logic [5:0] waddr;
    logic [7:0] wdata;
    logic [2:0] lock_new;
    logic reg_step;
    logic pin_step;

    assign sclk_rise = q.sclk_s & ~q.sclk_p;
    assign sclk_fall = ~q.sclk_s & q.sclk_p;
    assign in_frame = ~q.cs_s;
    // A frame only counts when exactly sixteen bits arrived before select rose
    assign commit = q.cs_s & ~q.cs_p & (q.bit_cnt == FRAME_BITS)
        & ~q.shift_in[FRAME_ZERO_BIT] & ~q.shift_in[FRAME_READ_BIT];
    assign locked = (q.lock == LOCK_ON);
    assign waddr = q.shift_in[13:8];
    assign wdata = q.shift_in[7:0];
    assign lock_new = wdata[LOCK_LSB +: 3];
    assign reg_step = commit & hit(waddr, ADDR_STEP_MOTION) & ~locked
        & wdata[STEP_BIT] & wdata[SRC_STEP_BIT];
    assign pin_step = ~q.step_motion[SRC_STEP_BIT] & q.step_s & ~q.step_p;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        d = q;
        d.sclk_m = spi_sclk;
        d.sclk_s = q.sclk_m;
        d.sclk_p = q.sclk_s;
        d.cs_m = spi_cs_n;
        d.cs_s = q.cs_m;
        d.cs_p = q.cs_s;
        d.mosi_m = spi_mosi;
        d.mosi_s = q.mosi_m;
        d.step_m = step_pin;
        d.step_s = q.step_m;
        d.step_p = q.step_s;
        d.dir_m = dir_pin;
        d.dir_s = q.dir_m;
        d.off_m = drive_off_pin;
        d.off_s = q.off_m;
        d.miso_oe_n = q.cs_s;

        if (!in_frame)
        begin
            d.bit_cnt = 5'h00;
            d.shift_out = 8'h00;
            d.miso = 1'b0;
        end
        else
        begin
            // Sample on the falling edge, shift out on the rising edge
            if (sclk_fall)
            begin
                d.shift_in = {q.shift_in[14:0], q.mosi_s};
                if (q.bit_cnt != CNT_MAX)
                    d.bit_cnt = 5'(q.bit_cnt + 5'h01);
                if (q.bit_cnt == ADDR_DONE_CNT)
                    d.shift_out = read_mux({q.shift_in[4:0], q.mosi_s}, q);
            end
            if (sclk_rise)
            begin
                d.miso = q.shift_out[7];
                d.shift_out = {q.shift_out[6:0], 1'b0};
            end
        end

        if (commit && !locked)
        begin
            if (hit(waddr, ADDR_TORQUE_SLEW))
                d.torque_slew = wdata;
            if (hit(waddr, ADDR_OUTPUT_CHOP))
                d.output_chop = wdata;
            if (hit(waddr, ADDR_STEP_MOTION))
                d.step_motion = wdata & STEP_CLEAR_MASK;
        end

        if (commit && hit(waddr, ADDR_LOCK_CTRL))
        begin
            if (!locked && lock_new == LOCK_ON)
                d.lock = LOCK_ON;
            else if (locked && lock_new == LOCK_OFF)
                d.lock = LOCK_OFF;
        end
        // Fault clear stays writable even while locked
        d.flt_clr = commit & hit(waddr, ADDR_LOCK_CTRL) & wdata[FLT_CLR_BIT];

        d.step_pulse = reg_step | pin_step;
        d.step_dir = q.step_motion[SRC_DIR_BIT] ? q.step_motion[DIR_BIT] : q.dir_s;
        d.hiz = q.output_chop[HIZ_BIT] | q.off_s;
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
            q <= RST_STATE;
        else
            q <= d;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign spi_miso = q.miso;
    assign spi_miso_oe_n = q.miso_oe_n;
    assign torque_scale = q.torque_slew[TORQUE_LSB +: 4];
    assign slew_select = q.torque_slew[SLEW_LSB +: 2];
    assign pwm_off_time = q.output_chop[OFF_TIME_LSB +: 2];
    assign decay_mode = q.output_chop[DECAY_LSB +: 3];
    assign substep_resolution = q.step_motion[SUBSTEP_LSB +: 4];
    assign step_dir = q.step_dir;
    assign step_pulse = q.step_pulse;
    assign outputs_hiz = q.hiz;
    assign fault_clear_pulse = q.flt_clr;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    sequence s_pin_off;
        drive_off_pin [*4];
    endsequence

    sequence s_reg_step_write;
        commit && hit(waddr, ADDR_STEP_MOTION) && !locked && wdata[STEP_BIT]
            && wdata[SRC_STEP_BIT];
    endsequence

    property p_reset_torque;
        $fell(srst) |-> (torque_scale == 4'h0) && (slew_select == 2'h0)
            && (q.torque_slew[3:2] == 2'h0);
    endproperty
    a_reset_torque: assert property (p_reset_torque)
        else $error("torque or slew not zero after reset");

    property p_reset_chop;
        $fell(srst) |-> (pwm_off_time == 2'h1) && (decay_mode == 3'h7)
            && (substep_resolution == 4'h0) && (outputs_hiz == HIZ_RESET);
    endproperty
    a_reset_chop: assert property (p_reset_chop)
        else $error("chop, decay or substep reset value wrong");

    property p_pin_off;
        s_pin_off |=> outputs_hiz;
    endproperty
    a_pin_off: assert property (p_pin_off)
        else $error("drive off pin did not force high impedance");

    property p_reg_off;
        q.output_chop[HIZ_BIT] [*2] |=> outputs_hiz;
    endproperty
    a_reg_off: assert property (p_reg_off)
        else $error("disable bit did not force high impedance");

    property p_reg_dir;
        q.step_motion[SRC_DIR_BIT] |=> step_dir == $past(q.step_motion[DIR_BIT]);
    endproperty
    a_reg_dir: assert property (p_reg_dir)
        else $error("direction did not follow register bit");

    property p_reg_step;
        s_reg_step_write |=> step_pulse ##1 !step_pulse;
    endproperty
    a_reg_step: assert property (p_reg_step)
        else $error("register step did not give a single pulse");

    property p_step_clears;
        !q.step_motion[STEP_BIT];
    endproperty
    a_step_clears: assert property (p_step_clears)
        else $error("step bit read back as one");

    property p_no_pin_step;
        (q.step_motion[SRC_STEP_BIT] && !commit) |=> !step_pulse;
    endproperty
    a_no_pin_step: assert property (p_no_pin_step)
        else $error("pin step passed while register source selected");

    property p_lock_holds;
        (locked && commit) |=> $stable(q.torque_slew) && $stable(q.output_chop)
            && $stable(q.step_motion);
    endproperty
    a_lock_holds: assert property (p_lock_holds)
        else $error("register changed while locked");

    property p_pin_step;
        (q.step_s && !q.step_p && !q.step_motion[SRC_STEP_BIT]) |=> step_pulse;
    endproperty
    a_pin_step: assert property (p_pin_step)
        else $error("pin step edge gave no pulse");

    sequence s_fault_clear_write;
        commit && hit(waddr, ADDR_LOCK_CTRL) && wdata[FLT_CLR_BIT];
    endsequence

    property p_fault_clear;
        s_fault_clear_write |=> fault_clear_pulse ##1 !fault_clear_pulse;
    endproperty
    a_fault_clear: assert property (p_fault_clear)
        else $error("fault clear write did not give a single pulse");

    property p_hiz_release;
        (!q.output_chop[HIZ_BIT] && !q.off_s) |=> !outputs_hiz;
    endproperty
    a_hiz_release: assert property (p_hiz_release)
        else $error("outputs stayed high impedance with bit and pin low");

endmodule : sdc_regs

/* pkg/sdc_pkg.sv */
// Notes on behaviour
// - Torque scale resets zero, 6.25 percent steps
// - Slew select resets zero, four edge rates
// - PWM off-time resets to code 01
// - Decay mode resets to 111, eight schemes
// - Output disable bit tri-states bridges; variant reset
// - Outputs high impedance when bit OR pin
// - Direction source: pin at zero, register one
// - Step source: pin at zero, register one
// - Register direction bit steers indexer direction
// - Register step write advances exactly one step
// - Step bit self-clears, always reads zero
// - Substep resolution resets 0000, codes to 1010
// - Lock code 110 blocks writes to registers 03 to 05, 011 unlocks
package sdc_pkg;

    // ------------------------------------------------------------
    // Serial frame: [15] zero, [14] read, [13:8] address, [7:0] data
    // ------------------------------------------------------------
    localparam int ADDR_W = 6;
    localparam logic [4:0] FRAME_BITS = 5'h10;
    localparam logic [4:0] ADDR_DONE_CNT = 5'h07;
    localparam logic [4:0] CNT_MAX = 5'h1F;
    localparam int FRAME_ZERO_BIT = 15;
    localparam int FRAME_READ_BIT = 14;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [5:0] ADDR_TORQUE_SLEW = 6'h03;
    localparam logic [5:0] ADDR_OUTPUT_CHOP = 6'h04;
    localparam logic [5:0] ADDR_STEP_MOTION = 6'h05;
    localparam logic [5:0] ADDR_LOCK_CTRL = 6'h06;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int TORQUE_LSB = 4;
    localparam int SLEW_LSB = 0;
    localparam int HIZ_BIT = 7;
    localparam int OFF_TIME_LSB = 3;
    localparam int DECAY_LSB = 0;
    localparam int DIR_BIT = 7;
    localparam int STEP_BIT = 6;
    localparam int SRC_DIR_BIT = 5;
    localparam int SRC_STEP_BIT = 4;
    localparam int SUBSTEP_LSB = 0;
    localparam int FLT_CLR_BIT = 7;
    localparam int LOCK_LSB = 4;

    // ------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------
    localparam logic [7:0] TORQUE_SLEW_RESET = 8'h00;
    localparam logic [6:0] OUTPUT_CHOP_RESET = 7'h0F;
    localparam logic [7:0] STEP_MOTION_RESET = 8'h00;
    localparam logic [7:0] STEP_CLEAR_MASK = 8'hBF;
    localparam logic [2:0] LOCK_ON = 3'h6;
    localparam logic [2:0] LOCK_OFF = 3'h3;

endpackage : sdc_pkg

/* bench/sdc_host_model.sv */
`timescale 1ns/1ns
module sdc_host_model
    import sdc_pkg::*;
(
    input wire logic sys_clk,
    output logic spi_sclk,
    output logic spi_cs_n,
    output logic spi_mosi,
    input wire logic spi_miso
);
    initial
    begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end

    // Mode 1 frame; each clock phase held 6 cycles, above the 4-cycle minimum
    task automatic xfer(input logic [15:0] frm, output logic [7:0] rd);
        int i;
        @(negedge sys_clk);
        spi_cs_n = 1'b0;
        repeat (6) @(negedge sys_clk);
        for (i = 15; i >= 0; i--)
        begin
            spi_sclk = 1'b1;
            spi_mosi = frm[i];
            repeat (6) @(negedge sys_clk);
            if (i < 8)
                rd[i] = spi_miso;
            spi_sclk = 1'b0;
            repeat (6) @(negedge sys_clk);
        end
        spi_cs_n = 1'b1;
        // Released data line toggles so a stale level never passes for data
        spi_mosi = ~spi_mosi;
        repeat (8) @(negedge sys_clk);
    endtask : xfer
endmodule : sdc_host_model

/* bench/stepper_drive_control_regs_test.sv */
`timescale 1ns/1ns
module stepper_drive_control_regs_test
    import sdc_pkg::*;
;
    logic sys_clk, srst, spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe_n;
    logic step_pin, dir_pin, drive_off_pin, step_dir, step_pulse, outputs_hiz;
    logic fault_clear_pulse;
    logic [3:0] torque_scale, substep_resolution;
    logic [1:0] slew_select, pwm_off_time;
    logic [2:0] decay_mode;
    logic [7:0] v;
    int i, pulses, clears, fails, num_checks;

    sdc_regs #(.HIZ_RESET(1'b0)) dut (.sys_clk(sys_clk), .srst(srst),
        .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
        .spi_miso(spi_miso), .spi_miso_oe_n(spi_miso_oe_n), .step_pin(step_pin),
        .dir_pin(dir_pin), .drive_off_pin(drive_off_pin), .torque_scale(torque_scale),
        .slew_select(slew_select), .pwm_off_time(pwm_off_time), .decay_mode(decay_mode),
        .substep_resolution(substep_resolution), .step_dir(step_dir),
        .step_pulse(step_pulse), .outputs_hiz(outputs_hiz),
        .fault_clear_pulse(fault_clear_pulse));

    sdc_host_model host (.sys_clk(sys_clk), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // Counting high cycles also proves each pulse is one cycle wide
    always @(posedge sys_clk)
    begin
        if (step_pulse === 1'b1)
            pulses++;
        if (fault_clear_pulse === 1'b1)
            clears++;
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [7:0] x;
        host.xfer({2'b00, a, d}, x);
    endtask : wr

    task automatic rdc(input logic [5:0] a, input logic [7:0] exp);
        logic [7:0] x;
        host.xfer({2'b01, a, 8'h00}, x);
        check(x, exp);
    endtask : rdc

    task automatic pin_step;
        step_pin = 1'b1;
        repeat (8) @(negedge sys_clk);
        step_pin = 1'b0;
        repeat (8) @(negedge sys_clk);
    endtask : pin_step

    task automatic finish_test;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : finish_test

    initial
    begin
        repeat (100000) @(posedge sys_clk);
        fails++;
        finish_test();
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial
    begin
        srst = 1'b1;
        step_pin = 1'b0;
        dir_pin = 1'b0;
        drive_off_pin = 1'b0;
        repeat (8) @(negedge sys_clk);
        srst = 1'b0;
        repeat (4) @(negedge sys_clk);
        check({7'h0, spi_miso_oe_n}, 8'h01);
        rdc(ADDR_TORQUE_SLEW, 8'h00);
        rdc(ADDR_OUTPUT_CHOP, 8'h0F);
        rdc(ADDR_STEP_MOTION, 8'h00);
        check({3'h0, pwm_off_time, decay_mode}, 8'h0F);
        check({7'h0, outputs_hiz}, 8'h00);
        check({7'h0, step_dir}, 8'h00);
        for (i = 0; i < 16; i++)
        begin
            v = 8'(i);
            wr(ADDR_TORQUE_SLEW, {v[3:0], 2'b00, v[1:0]});
            check({torque_scale, 2'b00, slew_select}, {v[3:0], 2'b00, v[1:0]});
        end
        wr(ADDR_TORQUE_SLEW, 8'h5C);
        rdc(ADDR_TORQUE_SLEW, 8'h5C);
        for (i = 0; i < 8; i++)
        begin
            v = 8'(i);
            wr(ADDR_OUTPUT_CHOP, {3'h0, v[1:0], v[2:0]});
            check({3'h0, pwm_off_time, decay_mode}, {3'h0, v[1:0], v[2:0]});
        end
        // Only defined resolution codes are sent
        for (i = 0; i < 11; i++)
        begin
            v = 8'(i);
            wr(ADDR_STEP_MOTION, {4'h0, v[3:0]});
            check({4'h0, substep_resolution}, {4'h0, v[3:0]});
        end
        rdc(ADDR_STEP_MOTION, 8'h0A);
        wr(ADDR_OUTPUT_CHOP, 8'h80);
        check({7'h0, outputs_hiz}, 8'h01);
        wr(ADDR_OUTPUT_CHOP, 8'h0F);
        check({7'h0, outputs_hiz}, 8'h00);
        drive_off_pin = 1'b1;
        repeat (8) @(negedge sys_clk);
        check({7'h0, outputs_hiz}, 8'h01);
        drive_off_pin = 1'b0;
        repeat (8) @(negedge sys_clk);
        check({7'h0, outputs_hiz}, 8'h00);
        dir_pin = 1'b1;
        repeat (8) @(negedge sys_clk);
        check({7'h0, step_dir}, 8'h01);
        wr(ADDR_STEP_MOTION, 8'h20);
        check({7'h0, step_dir}, 8'h00);
        wr(ADDR_STEP_MOTION, 8'hA0);
        check({7'h0, step_dir}, 8'h01);
        wr(ADDR_STEP_MOTION, 8'h00);
        pulses = 0;
        pin_step();
        check(8'(pulses), 8'h01);
        wr(ADDR_STEP_MOTION, 8'h10);
        pulses = 0;
        pin_step();
        check(8'(pulses), 8'h00);
        wr(ADDR_STEP_MOTION, 8'h50);
        check(8'(pulses), 8'h01);
        rdc(ADDR_STEP_MOTION, 8'h10);
        wr(ADDR_LOCK_CTRL, 8'h60);
        rdc(ADDR_LOCK_CTRL, 8'h60);
        wr(ADDR_TORQUE_SLEW, 8'h11);
        rdc(ADDR_TORQUE_SLEW, 8'h5C);
        clears = 0;
        wr(ADDR_LOCK_CTRL, 8'h80);
        check(8'(clears), 8'h01);
        wr(ADDR_LOCK_CTRL, 8'h30);
        wr(ADDR_TORQUE_SLEW, 8'h11);
        rdc(ADDR_TORQUE_SLEW, 8'h11);
        rdc(6'h3F, 8'h00);
        finish_test();
    end
endmodule : stepper_drive_control_regs_test
